/* hw/osb_pkg.sv */
/*
  Shared constants and carriers for the option strap block: register map,
  host address windows, reset pulse timing and interrupt bit layout.
  Assumes a single 125 MHz clock and an 18-bit host byte address space.
*/
package osb_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // Bus reset pulse lengths in nanoseconds and the derived cycle counts.
  localparam int SCSI_RST_LONG_NS = 25000;
  localparam int SCSI_RST_SHORT_NS = 10000;
  localparam int RST_CNT_W = 12;
  localparam logic [RST_CNT_W-1:0] RST_LONG_CYC =
    RST_CNT_W'((SCSI_RST_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // The short pulse must stay strictly under its limit, so one cycle is dropped.
  localparam logic [RST_CNT_W-1:0] RST_SHORT_CYC =
    RST_CNT_W'(SCSI_RST_SHORT_NS / CLK_PERIOD_NS - 1);

  // Host byte addresses (18 bit).
  localparam int HADDR_W = 18;
  localparam logic [HADDR_W-1:0] TICK_REG_ADDR = 18'h3ff66;
  localparam logic [HADDR_W-1:0] BOOT_AUTO_BASE = 18'h3ea00;
  localparam logic [HADDR_W-1:0] BOOT_CONS_BASE = 18'h3f600;
  localparam int BOOT_WIN_SHIFT = 9;
  localparam int BOOT_IDX_W = 9;
  localparam logic [15:0] EMPTY_SOCKET_DATA = 16'hffff;
  localparam int TICK_IE_BIT = 6;
  localparam logic [15:0] TICK_REG_RESET = 16'h0000;

  // Register port map.
  localparam int RADDR_W = 5;
  localparam logic [RADDR_W-1:0] REG_STATUS = 5'h00;
  localparam logic [RADDR_W-1:0] REG_MASK = 5'h04;
  localparam logic [RADDR_W-1:0] REG_STRAPS = 5'h08;
  localparam logic [RADDR_W-1:0] REG_CONTROL = 5'h0c;
  localparam logic [RADDR_W-1:0] REG_BOOT_ADDR = 5'h10;
  localparam logic [RADDR_W-1:0] REG_BOOT_DATA = 5'h14;
  localparam int CTRL_BUS_RESET_BIT = 0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // Status bit positions.
  localparam int ST_PARITY = 0;
  localparam int ST_RST_DONE = 1;
  localparam int ST_TICK_WR = 2;
  localparam int ST_BOOT_HIT = 3;
  localparam int ST_W = 4;

  // Host bus interrupt level of this card.
  localparam logic [1:0] BUS_INTR_LEVEL = 2'h0;

  typedef struct packed {
    logic short_bus_reset_strap;
    logic tick_clock_enable_strap;
    logic boot_rom_disable_strap;
    logic bus_parity_check_strap;
  } osb_straps_s;

  typedef struct packed {
    logic valid;
    logic we;
    logic [HADDR_W-1:0] addr;
    logic [15:0] wdata;
  } osb_host_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity;
    logic data_phase;
  } osb_scsi_byte_s;

endpackage : osb_pkg

/* hw/osb_boot_store.sv */
/*
  Word store standing in for the bootstrap sockets: one write port, one
  read port, read data registered one cycle after the address.
  Assumes the caller keeps the write and read addresses in range.
*/
`timescale 1ns/10ps
module osb_boot_store
  import osb_pkg::*;
(
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [BOOT_IDX_W-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [BOOT_IDX_W-1:0] rd_addr,
  output logic [15:0] rd_data_q
);

  logic [15:0] mem [0:(1<<BOOT_IDX_W)-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data_q <= mem[rd_addr];
  end

endmodule : osb_boot_store

/* hw/osb_top.sv */
/*
  Option strap logic of the disk controller card: bus reset pulse length,
  tick clock register decode, bootstrap windows, bus parity abort and the
  host interrupt chain, plus a small register port with sticky status.
  Assumes straps are static and all inputs are synchronous to mclk.
*/
// Notes on behaviour
// - Bus reset pulse lasts 25 us, or under 10 us with short strap.
// - Tick clock register at 777546 answers only with its strap closed.
// - Boot disable strap closed: no answer at 765000 and 773000 windows.
// - Boot disable strap open: boot windows answer even with sockets empty.
// - Parity strap closed: check bus data parity, abort on error.
// - Parity error reported as hard data or operation incomplete; retryable.
// - Join four-level host interrupt scheme with daisy-chained grant.
`timescale 1ns/10ps
module osb_top
  import osb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire osb_straps_s straps_in,
  input wire logic boot_rom_fitted,
  input wire logic [RADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  output logic irq_q,
  input wire osb_host_req_s host_req,
  output logic host_ack_q,
  output logic [15:0] host_rdata_q,
  output logic tick_irq_en_q,
  input wire logic scsi_reset_req,
  output logic scsi_rst_q,
  input wire osb_scsi_byte_s scsi_in,
  output logic scsi_abort_q,
  output logic hard_data_error_q,
  output logic operation_incomplete_error_q,
  output logic bus_irq_q,
  output logic [1:0] bus_irq_level_q,
  input wire logic bus_grant_in,
  output logic bus_grant_out_q,
  output logic bus_vector_stb_q
);

  function automatic logic in_window(input logic [HADDR_W-1:0] a,
                                     input logic [HADDR_W-1:0] base);
    in_window = (a[HADDR_W-1:BOOT_WIN_SHIFT] == base[HADDR_W-1:BOOT_WIN_SHIFT]);
  endfunction : in_window

  osb_straps_s straps_q;
  logic strap_ok_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] events;
  logic [RST_CNT_W-1:0] rst_cnt_q;
  logic [15:0] tick_reg_q;
  logic [BOOT_IDX_W-1:0] boot_wr_addr_q;
  logic boot_wr;
  logic [15:0] boot_dout_q;
  logic hit_tick, hit_auto, hit_cons, hit_boot;
  logic p1_q, p1_tick_q, p1_boot_q;
  logic parity_bad;
  logic rd_status;

  always_ff @(posedge mclk) begin
    if (srst) begin
      strap_ok_q <= 1'b0;
    end else if (!strap_ok_q) begin
      straps_q <= straps_in;
      strap_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      scsi_rst_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (!scsi_rst_q && strap_ok_q &&
                 (scsi_reset_req || (reg_wr && reg_addr == REG_CONTROL &&
                                     reg_wdata[CTRL_BUS_RESET_BIT]))) begin
      scsi_rst_q <= 1'b1;
      rst_cnt_q <= straps_q.short_bus_reset_strap ? RST_SHORT_CYC : RST_LONG_CYC;
    end else if (scsi_rst_q) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
      if (rst_cnt_q == RST_CNT_W'(1)) begin
        scsi_rst_q <= 1'b0;
      end
    end
  end

  assign hit_tick = host_req.valid && strap_ok_q && straps_q.tick_clock_enable_strap &&
                    host_req.addr == TICK_REG_ADDR;
  assign hit_auto = in_window(host_req.addr, BOOT_AUTO_BASE);
  assign hit_cons = in_window(host_req.addr, BOOT_CONS_BASE);
  assign hit_boot = host_req.valid && strap_ok_q && !straps_q.boot_rom_disable_strap &&
                    (hit_auto || hit_cons);

  always_ff @(posedge mclk) begin
    if (srst) begin
      tick_reg_q <= TICK_REG_RESET;
    end else if (hit_tick && host_req.we) begin
      tick_reg_q <= host_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tick_irq_en_q <= 1'b0;
    end else begin
      tick_irq_en_q <= straps_q.tick_clock_enable_strap && tick_reg_q[TICK_IE_BIT];
    end
  end

  // Read data come from the store one cycle late, so the answer takes two stages.
  always_ff @(posedge mclk) begin
    if (srst) begin
      p1_q <= 1'b0;
      p1_tick_q <= 1'b0;
      p1_boot_q <= 1'b0;
    end else begin
      p1_q <= hit_tick || (hit_boot && !host_req.we);
      p1_tick_q <= hit_tick;
      p1_boot_q <= hit_boot && !host_req.we;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      host_ack_q <= 1'b0;
      host_rdata_q <= 16'h0000;
    end else begin
      host_ack_q <= p1_q;
      if (p1_tick_q) begin
        host_rdata_q <= tick_reg_q;
      end else if (p1_boot_q) begin
        host_rdata_q <= boot_rom_fitted ? boot_dout_q : EMPTY_SOCKET_DATA;
      end else begin
        host_rdata_q <= 16'h0000;
      end
    end
  end

  // The auto window sits in the lower half of the store, the console one above.
  osb_boot_store u_store (
    .mclk(mclk),
    .wr_en(boot_wr),
    .wr_addr(boot_wr_addr_q),
    .wr_data(reg_wdata[15:0]),
    .rd_addr({hit_cons, host_req.addr[BOOT_WIN_SHIFT-1:1]}),
    .rd_data_q(boot_dout_q)
  );

  assign boot_wr = reg_wr && reg_addr == REG_BOOT_DATA;

  always_ff @(posedge mclk) begin
    if (srst) begin
      boot_wr_addr_q <= '0;
    end else if (reg_wr && reg_addr == REG_BOOT_ADDR) begin
      boot_wr_addr_q <= reg_wdata[BOOT_IDX_W-1:0];
    end else if (boot_wr) begin
      boot_wr_addr_q <= boot_wr_addr_q + 1'b1;
    end
  end

  assign parity_bad = scsi_in.valid && strap_ok_q && straps_q.bus_parity_check_strap &&
                      !(^{scsi_in.data, scsi_in.parity});

  always_ff @(posedge mclk) begin
    if (srst) begin
      scsi_abort_q <= 1'b0;
      hard_data_error_q <= 1'b0;
      operation_incomplete_error_q <= 1'b0;
    end else begin
      scsi_abort_q <= parity_bad;
      hard_data_error_q <= parity_bad && scsi_in.data_phase;
      operation_incomplete_error_q <= parity_bad && !scsi_in.data_phase;
    end
  end

  assign events[ST_PARITY] = parity_bad;
  assign events[ST_RST_DONE] = scsi_rst_q && rst_cnt_q == RST_CNT_W'(1);
  assign events[ST_TICK_WR] = hit_tick && host_req.we;
  assign events[ST_BOOT_HIT] = hit_boot;
  assign rd_status = reg_rd && reg_addr == REG_STATUS;

  // A read clears the status, but an event in the same cycle survives it.
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= '0;
    end else begin
      status_q <= (rd_status ? '0 : status_q) | events;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_q <= MASK_RESET;
    end else if (reg_wr && reg_addr == REG_MASK) begin
      mask_q <= reg_wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((rd_status ? '0 : status_q) | events) & mask_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: reg_rdata_q <= {{(32-ST_W){1'b0}}, status_q};
        REG_MASK: reg_rdata_q <= {{(32-ST_W){1'b0}}, mask_q};
        REG_STRAPS: reg_rdata_q <= {26'h0, scsi_rst_q, strap_ok_q, straps_q};
        REG_BOOT_ADDR: reg_rdata_q <= {{(32-BOOT_IDX_W){1'b0}}, boot_wr_addr_q};
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_irq_q <= 1'b0;
      bus_irq_level_q <= BUS_INTR_LEVEL;
      bus_grant_out_q <= 1'b0;
      bus_vector_stb_q <= 1'b0;
    end else begin
      bus_irq_q <= irq_q;
      bus_irq_level_q <= BUS_INTR_LEVEL;
      bus_grant_out_q <= bus_grant_in && !bus_irq_q;
      bus_vector_stb_q <= bus_grant_in && bus_irq_q;
    end
  end

  // Checks.
  logic [RST_CNT_W:0] rst_len_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_len_q <= '0;
    end else if (scsi_rst_q) begin
      rst_len_q <= rst_len_q + 1'b1;
    end else begin
      rst_len_q <= '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  rst_long_len_a: assert property (
    $fell(scsi_rst_q) && !straps_q.short_bus_reset_strap
    |-> rst_len_q == {1'b0, RST_LONG_CYC})
    else $error("bus reset long pulse has wrong length");

  rst_short_len_a: assert property (
    $fell(scsi_rst_q) && straps_q.short_bus_reset_strap
    |-> rst_len_q == {1'b0, RST_SHORT_CYC})
    else $error("bus reset short pulse has wrong length");

  tick_off_a: assert property (
    host_req.valid && host_req.addr == TICK_REG_ADDR && !straps_q.tick_clock_enable_strap
    && !hit_boot |-> ##2 !host_ack_q)
    else $error("tick register answered while disabled");

  boot_block_a: assert property (
    host_req.valid && (hit_auto || hit_cons) && straps_q.boot_rom_disable_strap
    |-> ##2 !host_ack_q)
    else $error("boot window answered while disabled");

  boot_ack_a: assert property (
    hit_boot && !host_req.we && !boot_rom_fitted
    |-> ##2 host_ack_q && host_rdata_q == EMPTY_SOCKET_DATA)
    else $error("empty boot window not answered");

  parity_abort_a: assert property (
    scsi_in.valid && strap_ok_q && straps_q.bus_parity_check_strap
    && !(^{scsi_in.data, scsi_in.parity}) |=> scsi_abort_q)
    else $error("parity error did not abort");

  parity_class_a: assert property (
    scsi_abort_q |-> hard_data_error_q != operation_incomplete_error_q)
    else $error("parity error reported with no single class");

  straps_static_a: assert property (
    strap_ok_q && $past(strap_ok_q) |-> $stable(straps_q))
    else $error("captured straps changed");

  grant_pass_a: assert property (
    bus_grant_in && !bus_irq_q |=> bus_grant_out_q && !bus_vector_stb_q)
    else $error("grant not passed on");

  cov_reset_pulse_c: cover property ($fell(scsi_rst_q));
  cov_boot_read_c: cover property (hit_boot ##2 host_ack_q);
  cov_parity_c: cover property (scsi_abort_q && hard_data_error_q);
  cov_vector_c: cover property (bus_vector_stb_q);

endmodule : osb_top

/* dv/osb_far_model.sv */
/*
  Far side model: a host bus master and a bus target that sends bytes.
  Assumes osb_pkg and a running mclk; it drives only just after rising edges.
*/
`timescale 1ns/10ps
module osb_far_model
  import osb_pkg::*;
(
  input wire logic mclk,
  input wire logic host_ack_q,
  input wire logic [15:0] host_rdata_q,
  output osb_host_req_s host_req,
  output osb_scsi_byte_s scsi_in
);
  initial begin
    host_req = '0;
    scsi_in = '0;
  end

  // Lat is the cycle after the taking edge in which the answer came, or 0.
  task automatic host_access(input logic we, input logic [HADDR_W-1:0] a,
                             input logic [15:0] d, output int lat, output logic [15:0] rd);
    @(posedge mclk);
    host_req <= '{valid: 1'b1, we: we, addr: a, wdata: d};
    @(posedge mclk);
    // A released bus does not hold its last value, so the lines are flipped.
    host_req <= '{valid: 1'b0, we: ~we, addr: ~a, wdata: ~d};
    lat = 0;
    rd = 16'h0000;
    for (int n = 1; n <= 4; n++) begin
      #1;
      if (lat == 0 && host_ack_q === 1'b1) begin
        lat = n;
        rd = host_rdata_q;
      end
      @(posedge mclk);
    end
  endtask : host_access

  task automatic send_byte(input logic [7:0] d, input logic p, input logic ph);
    @(posedge mclk);
    scsi_in <= '{valid: 1'b1, data: d, parity: p, data_phase: ph};
    @(posedge mclk);
    scsi_in <= '{valid: 1'b0, data: ~d, parity: ~p, data_phase: ~ph};
    #1;
  endtask : send_byte
endmodule : osb_far_model

/* dv/osb_top_bench.sv */
/*
  Self-checking bench for osb_top with the far side model beside it.
  Assumes osb_pkg and osb_far_model are compiled first.
*/
`timescale 1ns/10ps
module osb_top_bench
  import osb_pkg::*;
;
  logic mclk, srst, boot_rom_fitted, reg_wr, reg_rd, scsi_reset_req, bus_grant_in;
  osb_straps_s straps_in;
  logic [RADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, v;
  osb_host_req_s host_req;
  osb_scsi_byte_s scsi_in;
  logic irq_q, host_ack_q, tick_irq_en_q, scsi_rst_q, scsi_abort_q, hard_data_error_q;
  logic operation_incomplete_error_q, bus_irq_q, bus_grant_out_q, bus_vector_stb_q;
  logic [15:0] host_rdata_q, rd;
  logic [1:0] bus_irq_level_q;
  int fails = 0, total_checks = 0, cycles = 0, lat;
  wire [2:0] err_seen = {scsi_abort_q, hard_data_error_q, operation_incomplete_error_q};

  osb_top osb_top_i (.mclk, .srst, .straps_in, .boot_rom_fitted, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_q, .irq_q, .host_req, .host_ack_q, .host_rdata_q,
    .tick_irq_en_q, .scsi_reset_req, .scsi_rst_q, .scsi_in, .scsi_abort_q,
    .hard_data_error_q, .operation_incomplete_error_q, .bus_irq_q, .bus_irq_level_q,
    .bus_grant_in, .bus_grant_out_q, .bus_vector_stb_q);
  osb_far_model osb_far_model_i (.mclk, .host_ack_q, .host_rdata_q, .host_req, .scsi_in);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic finish_test;
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [RADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [RADDR_W-1:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : rdr

  // The straps are flipped after capture to show they are held.
  task automatic do_reset(input osb_straps_s s);
    srst <= 1'b1;
    straps_in <= s;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    straps_in <= ~s;
    repeat (2) @(posedge mclk);
    rdr(REG_STRAPS, v);
    chk("straps", v & 32'h1f, {27'h0, 1'b1, s});
  endtask : do_reset

  task automatic t_regs;
    rdr(REG_MASK, v);
    chk("mask", v, {28'h0, MASK_RESET});
    wr(REG_STRAPS, 32'h0);
    rdr(REG_STRAPS, v);
    chk("straps_ro", v & 32'h1f, 32'h15);
    rdr(5'h18, v);
    chk("unmapped", v, 32'h0);
    chk("level", bus_irq_level_q, BUS_INTR_LEVEL);
  endtask : t_regs

  task automatic t_boot;
    wr(REG_BOOT_ADDR, 32'h1);
    wr(REG_BOOT_DATA, 32'h1234);
    wr(REG_BOOT_ADDR, 32'h100);
    wr(REG_BOOT_DATA, 32'hbeef);
    boot_rom_fitted <= 1'b1;
    osb_far_model_i.host_access(1'b0, BOOT_AUTO_BASE + 18'h2, 16'h0, lat, rd);
    chk("auto", {lat[15:0], rd}, {16'h2, 16'h1234});
    osb_far_model_i.host_access(1'b0, BOOT_CONS_BASE, 16'h0, lat, rd);
    chk("cons", {lat[15:0], rd}, {16'h2, 16'hbeef});
    osb_far_model_i.host_access(1'b1, BOOT_AUTO_BASE, 16'h5555, lat, rd);
    chk("boot_wr", lat, 0);
    boot_rom_fitted <= 1'b0;
    osb_far_model_i.host_access(1'b0, BOOT_CONS_BASE + 18'h1fe, 16'h0, lat, rd);
    chk("empty", {lat[15:0], rd}, {16'h2, EMPTY_SOCKET_DATA});
  endtask : t_boot

  task automatic t_tick;
    osb_far_model_i.host_access(1'b1, TICK_REG_ADDR, 16'h0040, lat, rd);
    chk("tick_wr", lat, 2);
    osb_far_model_i.host_access(1'b0, TICK_REG_ADDR, 16'h0, lat, rd);
    chk("tick_rd", {lat[15:0], rd}, {16'h2, 16'h0040});
    chk("tick_ie", tick_irq_en_q, 1);
    rdr(REG_STATUS, v);
    chk("tick_stat", v, (32'h1 << ST_TICK_WR) | (32'h1 << ST_BOOT_HIT));
  endtask : t_tick

  task automatic t_parity;
    rdr(REG_STATUS, v);
    osb_far_model_i.send_byte(8'h01, 1'b0, 1'b1);
    chk("good", err_seen, 0);
    osb_far_model_i.send_byte(8'h01, 1'b1, 1'b1);
    chk("hard", err_seen, 3'b110);
    osb_far_model_i.send_byte(8'h03, 1'b0, 1'b0);
    chk("incomplete", err_seen, 3'b101);
    rdr(REG_STATUS, v);
    chk("par_stat", v[ST_PARITY], 1);
    chk("masked", irq_q, 0);
  endtask : t_parity

  task automatic t_off;
    osb_far_model_i.host_access(1'b0, TICK_REG_ADDR, 16'h0, lat, rd);
    chk("tick_off", lat, 0);
    osb_far_model_i.host_access(1'b0, BOOT_AUTO_BASE, 16'h0, lat, rd);
    chk("auto_off", lat, 0);
    osb_far_model_i.host_access(1'b0, BOOT_CONS_BASE + 18'h1fe, 16'h0, lat, rd);
    chk("cons_off", lat, 0);
    osb_far_model_i.send_byte(8'h01, 1'b1, 1'b1);
    chk("no_check", err_seen, 0);
    chk("tick_ie0", tick_irq_en_q, 0);
  endtask : t_off

  task automatic t_rst(input logic use_req, input int exp_len);
    int n;
    rdr(REG_STATUS, v);
    wr(REG_MASK, 32'h1 << ST_RST_DONE);
    if (use_req) begin
      @(posedge mclk);
      scsi_reset_req <= 1'b1;
      @(posedge mclk);
      scsi_reset_req <= 1'b0;
    end else begin
      wr(REG_CONTROL, 32'h1);
    end
    n = 0;
    repeat (4000) begin
      #1;
      if (scsi_rst_q === 1'b1) n++;
      else if (n > 0) break;
      @(posedge mclk);
    end
    chk("rst_len", n, exp_len);
    repeat (2) @(posedge mclk);
    bus_grant_in <= 1'b1;
    #1;
    chk("irq", {irq_q, bus_irq_q}, 2'b11);
    repeat (2) @(posedge mclk);
    #1;
    chk("grant_take", {bus_grant_out_q, bus_vector_stb_q}, 2'b01);
    rdr(REG_STATUS, v);
    chk("rst_stat", v, 32'h1 << ST_RST_DONE);
    repeat (4) @(posedge mclk);
    bus_grant_in <= 1'b0;
    #1;
    chk("grant_pass", {irq_q, bus_grant_out_q, bus_vector_stb_q}, 3'b010);
  endtask : t_rst

  initial begin
    srst = 1'b1;
    straps_in = '0;
    boot_rom_fitted = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    scsi_reset_req = 1'b0;
    bus_grant_in = 1'b0;
    do_reset(4'b0101);
    t_regs;
    t_boot;
    t_tick;
    t_parity;
    t_rst(1'b0, 3125);
    do_reset(4'b1010);
    t_off;
    t_rst(1'b1, 1249);
    finish_test;
  end
endmodule : osb_top_bench
